// ### dv/triple_timer_pwm_capture_unit_tb.sv
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin \
  err_total++; $display("mismatch %s exp %0h got %0h", n, e, s); end end

module triple_timer_pwm_capture_unit_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic pready, pslverr, irq, osc, lst;
  logic [2:0] ev, cap;
  wire [5:0] outs;
  logic [32:0] exp_q[$];
  logic [32:0] e;
  int err_total = 0, checks = 0, ms = 0, tmo = 0;
  int cyc, win, seen, osel, p, m, tt;
  // Four-state sum, so an unknown output cannot count as zero
  logic [31:0] hi;
  integer seed = 46994;
  int dv[3][7] = '{'{2, 4, 8, 32, 128, 512, 2048},
    '{1, 2, 4, 8, 64, 512, 2048}, '{1, 2, 4, 8, 64, 2048, 8}};
  logic [7:0] ca[3] = '{8'h00, 8'h10, 8'h1c};
  logic [7:0] pa[3] = '{8'h04, 8'h14, 8'h20};
  logic [7:0] xa[3] = '{8'h08, 8'h18, 8'h24};

  always #5 pclk = ~pclk;

  ttu_timers u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .small_timer_event_in(ev[0]), .wide_timer_a_event_in(ev[1]),
    .wide_timer_b_event_in(ev[2]), .capture_trigger_a(cap[0]),
    .capture_trigger_b(cap[1]), .capture_trigger_c(cap[2]),
    .fast_internal_oscillator(osc),
    .small_timer_toggle_out(outs[0]), .wide_timer_a_compare_out(outs[1]),
    .wide_timer_b_toggle_out(outs[2]), .small_timer_pwm_out(outs[3]),
    .wide_timer_a_pwm_out(outs[4]), .wide_timer_b_pwm_out(outs[5]),
    .irq(irq));
  ttu_pins u_pins (.pclk(pclk), .ev(ev), .cap(cap), .osc(osc));

  // ==========================================================
  // Driver tasks
  task results;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic x);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) exp_q.push_back({x, d});
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Observer starts on the edge after setup, so no same-step race
  task measure(input int o, input int md, input int x);
    @(posedge pclk);
    osel <= o;
    lst <= outs[o];
    seen <= 0;
    hi <= 0;
    win <= 80;
    exp_q.push_back(x);
    ms <= md;
    @(posedge pclk);
    wait (ms == 0);
  endtask

  // ==========================================================
  // Observer
  // Longest run is about 16k cycles
  always @(posedge pclk) begin
    tmo <= tmo + 1;
    if (tmo == 60000) begin
      err_total++;
      results;
    end
  end

  always @(posedge pclk) begin
    if (pready && !pwrite) begin
      e = exp_q.pop_front();
      `CHK("read", e, {pslverr, prdata})
    end
    if (ms == 1) begin
      cyc <= cyc + 1;
      if (outs[osel] !== lst) begin
        lst <= outs[osel];
        cyc <= 1;
        seen <= seen + 1;
        if (seen == 1) begin
          e = exp_q.pop_front();
          `CHK("interval", e, 33'(cyc))
          ms <= 0;
        end
      end
    end
    if (ms == 2) begin
      if (win != 0) begin
        hi <= hi + outs[osel];
        win <= win - 1;
      end else begin
        e = exp_q.pop_front();
        `CHK("high", e, 33'(hi))
        ms <= 0;
      end
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h00, 32'h0000_0000, 0);
    apb(0, 8'h04, 32'h0000_00ff, 0);
    apb(0, 8'h14, 32'h0000_ffff, 0);
    apb(0, 8'h20, 32'h0000_ffff, 0);
    apb(0, 8'h38, 32'h0000_0000, 0);
    apb(0, 8'h40, 32'h0000_0000, 1);
    $display("test reset done");
    apb(1, 8'h28, 32'h0000_0038, 0);
    for (int t = 0; t < 3; t++)
      for (int s = 0; s < 7; s++) begin
        p = (t == 0 && s == 0) ? ($random(seed) & 7) : 0;
        apb(1, pa[t], p, 0);
        apb(1, ca[t], s << 3 | 1, 0);
        measure(t, 1, (p + 1) * dv[t][s]);
        apb(1, ca[t], 32'h0000_0000, 0);
      end
    $display("test clocks done");
    // Event clock, five events, then one trigger
    apb(1, 8'h28, 32'h0000_0000, 0);
    for (int t = 0; t < 3; t++) begin
      apb(1, ca[t], t == 0 ? 32'h0000_003d : 32'h0000_003b, 0);
      u_pins.pulse(t, 0, 5);
      u_pins.pulse(t, 1, 1);
      apb(0, xa[t], 32'h0000_0005, 0);
      apb(1, ca[t], 32'h0000_0000, 0);
    end
    $display("test capture done");
    apb(0, 8'h38, 32'h0000_003f, 0);
    m = ($random(seed) & 32'h0000_003f) | 1;
    apb(1, 8'h3c, m, 0);
    apb(0, 8'h3c, m, 0);
    `CHK("irq", 1'b1, irq)
    apb(1, 8'h3c, 32'h0000_0000, 0);
    apb(1, 8'h3c, 32'h0000_0008, 0);
    apb(1, 8'h38, 32'h0000_0038, 0);
    apb(0, 8'h38, 32'h0000_0007, 0);
    `CHK("irq", 1'b0, irq)
    apb(1, 8'h38, 32'h0000_0007, 0);
    apb(0, 8'h38, 32'h0000_0000, 0);
    $display("test irq done");
    apb(1, 8'h28, 32'h0000_0038, 0);
    apb(1, 8'h0c, 32'h0000_0002, 0);
    apb(1, 8'h18, 32'h0000_0001, 0);
    apb(1, 8'h24, 32'h0000_0001, 0);
    for (int t = 0; t < 3; t++) apb(1, pa[t], 32'h0000_0003, 0);
    // Small PWM, wide A/B repeat, then wide A/B one-shot
    for (int k = 0; k < 5; k++) begin
      tt = (k == 0) ? 0 : 2 - k % 2;
      apb(1, ca[tt], k == 0 ? 32'h0000_0003 : k < 3 ? 32'h0000_0007 :
          32'h0000_0005, 0);
      // One-shot is watched from enable, so its single pulse counts
      if (k < 3) repeat (40) @(posedge pclk);
      measure(tt + 3, 2, k == 0 ? 40 : k < 3 ? 20 : 1);
      apb(1, ca[tt], 32'h0000_0000, 0);
    end
    $display("test pulse done");
    // Reset in mid-run must bring the period back to its reset value
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h04, 32'h0000_00ff, 0);
    $display("test mid reset done");
    results;
  end
endmodule

// ### dv/ttu_checker.sv
module ttu_checker (
  // Bus
  input logic pclk,
  input logic presetn,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  // Pins and interrupt
  input logic small_timer_toggle_out,
  input logic small_timer_pwm_out,
  input logic irq
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================
  // Bus handshake
  property p_rdy_wait;
    psel && penable && !pready |=> pready;
  endproperty
  a_rdy_wait: assert property (p_rdy_wait)
    else $error("access not answered after one wait state");
  property p_rdy_pulse;
    pready |=> !pready;
  endproperty
  a_rdy_pulse: assert property (p_rdy_pulse)
    else $error("ready held longer than one cycle");
  property p_rdy_acc;
    pready |-> psel && penable;
  endproperty
  a_rdy_acc: assert property (p_rdy_acc)
    else $error("ready outside an access phase");
  property p_err_rdy;
    pslverr |-> pready;
  endproperty
  a_err_rdy: assert property (p_err_rdy)
    else $error("error flag without ready");
  // Unmapped reads must also return zero
  property p_err_map;
    pready && paddr > 8'h3c |-> pslverr && (pwrite || prdata == 0);
  endproperty
  a_err_map: assert property (p_err_map)
    else $error("unmapped access not refused");
  property p_ok_map;
    pready && paddr <= 8'h3c && paddr[1:0] == 2'b00 |-> !pslverr;
  endproperty
  a_ok_map: assert property (p_ok_map)
    else $error("mapped access refused");

  // ==========================================================
  // Outputs
  // Fastest small clock is fx/2, so no back-to-back flips
  property p_tog_gap;
    $changed(small_timer_toggle_out) |=> $stable(small_timer_toggle_out);
  endproperty
  a_tog_gap: assert property (p_tog_gap)
    else $error("small toggle output flipped twice in a row");
  property p_irq_off;
    psel && penable && pready && pwrite && paddr == 8'h3c &&
      pwdata[5:0] == 6'h00 |=> ##1 !irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt high with all sources masked");
  property p_rst_quiet;
    $rose(presetn) |-> !pready && !irq && !small_timer_pwm_out;
  endproperty
  a_rst_quiet: assert property (p_rst_quiet)
    else $error("outputs active right after reset");

  c_read: cover property (pready && !pwrite);
  c_irq: cover property ($rose(irq));
  c_tog: cover property ($changed(small_timer_toggle_out));
endmodule

bind ttu_timers ttu_checker u_chk (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .irq(irq),
  .small_timer_toggle_out(small_timer_toggle_out),
  .small_timer_pwm_out(small_timer_pwm_out)
);

// ### dv/ttu_pins.sv
module ttu_pins (
  // Clock
  input logic pclk,
  // Pins toward the timers
  output logic [2:0] ev,
  output logic [2:0] cap,
  output logic osc
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    ev = 3'h0;
    cap = 3'h0;
    osc = 1'b0;
  end
  // Oscillator runs free at an eighth of the system clock
  always begin
    repeat (4) @(posedge pclk);
    osc <= ~osc;
  end
  // Three cycles high and low so the two-flop sync sees every edge
  task automatic pulse(input int k, input bit c, input int n);
    repeat (n) begin
      @(posedge pclk);
      if (c) cap[k] <= 1'b1;
      else ev[k] <= 1'b1;
      repeat (3) @(posedge pclk);
      if (c) cap[k] <= 1'b0;
      else ev[k] <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask
endmodule

// ### rtl/ttu_defs.vh
`ifndef TTU_DEFS_VH
`define TTU_DEFS_VH

// ==========================================================
// Register byte offsets
`define TTU_OFS_SMALL_CTRL  8'h00
`define TTU_OFS_SMALL_PER   8'h04
`define TTU_OFS_SMALL_CAP   8'h08
`define TTU_OFS_SMALL_DUTY  8'h0C
`define TTU_OFS_WA_CTRL     8'h10
`define TTU_OFS_WA_FIRST    8'h14
`define TTU_OFS_WA_SECOND   8'h18
`define TTU_OFS_WB_CTRL     8'h1C
`define TTU_OFS_WB_FIRST    8'h20
`define TTU_OFS_WB_SECOND   8'h24
`define TTU_OFS_PORT_FSEL   8'h28
`define TTU_OFS_SMALL_CNT   8'h2C
`define TTU_OFS_WA_CNT      8'h30
`define TTU_OFS_WB_CNT      8'h34
`define TTU_OFS_IRQ_STAT    8'h38
`define TTU_OFS_IRQ_MASK    8'h3C

// ==========================================================
// Control register fields
`define TTU_CTRL_EN         0
`define TTU_CTRL_MODE_LO    1
`define TTU_CTRL_MODE_HI    2
`define TTU_CTRL_CLK_LO     3
`define TTU_CTRL_CLK_HI     5

// Port function select fields and required codes
`define TTU_FSEL_WA_LO      3
`define TTU_FSEL_WA_HI      4
`define TTU_FSEL_WB_LO      5
`define TTU_FSEL_WB_HI      6
`define TTU_FSEL_WA_RUN     2'b11
`define TTU_FSEL_WB_RUN     2'b01
`define TTU_FSEL_CAPTURE    2'b00

// Interrupt status bits
`define TTU_IRQ_BITS        6
`define TTU_IRQ_SMALL_MATCH 0
`define TTU_IRQ_WA_MATCH    1
`define TTU_IRQ_WB_MATCH    2
`define TTU_IRQ_SMALL_CAP   3
`define TTU_IRQ_WA_CAP      4
`define TTU_IRQ_WB_CAP      5

// ==========================================================
// Core modes (internal encoding)
`define TTU_CORE_COUNT      2'b00
`define TTU_CORE_CAPTURE    2'b01
`define TTU_CORE_ONESHOT    2'b10
`define TTU_CORE_REPEAT     2'b11

// Small timer mode field codes
`define TTU_SMODE_COUNT     2'b00
`define TTU_SMODE_PWM       2'b01

// Clock select codes for the external event input and the fast oscillator
`define TTU_CLK_EVENT       3'b111
`define TTU_CLK_FAST_OSC    3'b110

// Prescaler width (largest divider is 2048)
`define TTU_PRE_W           11

// Reset values
`define TTU_RST_CTRL        8'h00
`define TTU_RST_SMALL       8'hFF
`define TTU_RST_WIDE        16'hFFFF

`endif

// ### rtl/ttu_timers.v
// The implementer's own choices: the APB register port and the address map.
`include "ttu_defs.vh"

// ==========================================================
// Shared counter core
module ttu_core #(
  parameter W = 16
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control
  input wire en,
  input wire [1:0] mode,
  input wire pin_ok,
  input wire tick,
  input wire cap_edge,
  input wire [W-1:0] period,
  input wire [W-1:0] duty,
  // Results
  output reg [W-1:0] cnt_q,
  output reg [W-1:0] cap_q,
  output reg toggle_q,
  output reg pwm_q,
  output reg match_q,
  output reg capev_q
);
  reg done_q;
  wire hit;

  assign hit = (cnt_q == period);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= {W{1'b0}};
      cap_q <= {W{1'b0}};
      toggle_q <= 1'b0;
      pwm_q <= 1'b0;
      match_q <= 1'b0;
      capev_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      match_q <= 1'b0;
      capev_q <= 1'b0;
      if (!en) begin
        cnt_q <= {W{1'b0}};
        pwm_q <= 1'b0;
        done_q <= 1'b0;
      end else begin
        case (mode)
          `TTU_CORE_COUNT: begin
            pwm_q <= 1'b0;
            if (tick) begin
              if (hit) begin
                cnt_q <= {W{1'b0}};
                toggle_q <= toggle_q ^ pin_ok;
                match_q <= 1'b1;
              end else begin
                cnt_q <= cnt_q + 1'b1;
              end
            end
          end
          `TTU_CORE_CAPTURE: begin
            pwm_q <= 1'b0;
            if (tick)
              cnt_q <= cnt_q + 1'b1;
            if (cap_edge) begin
              cap_q <= cnt_q;
              capev_q <= 1'b1;
            end
          end
          `TTU_CORE_ONESHOT, `TTU_CORE_REPEAT: begin
            // Output high while the count is below the duty value
            pwm_q <= pin_ok & ~done_q & (cnt_q < duty);
            if (tick && !done_q) begin
              if (hit) begin
                match_q <= 1'b1;
                if (mode == `TTU_CORE_ONESHOT)
                  done_q <= 1'b1;
                else
                  cnt_q <= {W{1'b0}};
              end else begin
                cnt_q <= cnt_q + 1'b1;
              end
            end
          end
          default: cnt_q <= cnt_q;
        endcase
      end
    end
  end
endmodule

// ==========================================================
// Top: three timers behind an APB slave
module ttu_timers (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Pins in
  input wire small_timer_event_in,
  input wire wide_timer_a_event_in,
  input wire wide_timer_b_event_in,
  input wire capture_trigger_a,
  input wire capture_trigger_b,
  input wire capture_trigger_c,
  input wire fast_internal_oscillator,
  // Pins out
  output wire small_timer_toggle_out,
  output wire small_timer_pwm_out,
  output wire wide_timer_a_compare_out,
  output wire wide_timer_a_pwm_out,
  output wire wide_timer_b_toggle_out,
  output wire wide_timer_b_pwm_out,
  // Interrupt
  output reg irq
);

  // ========================================================
  // Functions
  function pre_tick;
    input [`TTU_PRE_W-1:0] p;
    input [3:0] lg;
    reg [`TTU_PRE_W-1:0] m;
    begin
      m = ~({`TTU_PRE_W{1'b1}} << lg);
      pre_tick = ((p & m) == m);
    end
  endfunction

  // Divider exponent per select code; timer 0 small, 1 wide A, 2 wide B
  function [3:0] div_lg;
    input [1:0] tmr;
    input [2:0] sel;
    begin
      case (sel)
        3'd0: div_lg = (tmr == 2'd0) ? 4'd1 : 4'd0;
        3'd1: div_lg = (tmr == 2'd0) ? 4'd2 : 4'd1;
        3'd2: div_lg = (tmr == 2'd0) ? 4'd3 : 4'd2;
        3'd3: div_lg = (tmr == 2'd0) ? 4'd5 : 4'd3;
        3'd4: div_lg = (tmr == 2'd0) ? 4'd7 : 4'd6;
        3'd5: div_lg = (tmr == 2'd2) ? 4'd11 : 4'd9;
        default: div_lg = 4'd11;
      endcase
    end
  endfunction

  // ========================================================
  // Pin synchronisers: 2 flops then an edge flop
  reg [6:0] sync1_q;
  reg [6:0] sync2_q;
  reg [6:0] sync3_q;
  wire [6:0] rise;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 7'h00;
      sync2_q <= 7'h00;
      sync3_q <= 7'h00;
    end else begin
      sync1_q <= {fast_internal_oscillator, capture_trigger_c,
                  capture_trigger_b, capture_trigger_a,
                  wide_timer_b_event_in, wide_timer_a_event_in,
                  small_timer_event_in};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end
  assign rise = sync2_q & ~sync3_q;

  // ========================================================
  // Registers
  reg [7:0] s_ctrl_q;
  reg [7:0] s_per_q;
  reg [7:0] s_duty_q;
  reg [7:0] a_ctrl_q;
  reg [15:0] a_first_q;
  reg [15:0] a_second_q;
  reg [7:0] b_ctrl_q;
  reg [15:0] b_first_q;
  reg [15:0] b_second_q;
  reg [7:0] fsel_q;
  reg [`TTU_IRQ_BITS-1:0] ist_q;
  reg [`TTU_IRQ_BITS-1:0] imask_q;
  reg [`TTU_PRE_W-1:0] pre_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      pre_q <= {`TTU_PRE_W{1'b0}};
    else
      pre_q <= pre_q + 1'b1;
  end

  // ========================================================
  // Clock selection
  wire [2:0] s_sel = s_ctrl_q[`TTU_CTRL_CLK_HI:`TTU_CTRL_CLK_LO];
  wire [2:0] a_sel = a_ctrl_q[`TTU_CTRL_CLK_HI:`TTU_CTRL_CLK_LO];
  wire [2:0] b_sel = b_ctrl_q[`TTU_CTRL_CLK_HI:`TTU_CTRL_CLK_LO];
  wire s_tick = (s_sel == `TTU_CLK_EVENT) ? rise[0] :
                pre_tick(pre_q, div_lg(2'd0, s_sel));
  wire a_tick = (a_sel == `TTU_CLK_EVENT) ? rise[1] :
                pre_tick(pre_q, div_lg(2'd1, a_sel));
  // Fast oscillator is sampled, so it counts at most fx/2 here
  wire b_tick = (b_sel == `TTU_CLK_EVENT) ? rise[2] :
                (b_sel == `TTU_CLK_FAST_OSC) ? rise[6] :
                pre_tick(pre_q, div_lg(2'd2, b_sel));

  // ========================================================
  // Mode decode
  wire [1:0] s_mfld = s_ctrl_q[`TTU_CTRL_MODE_HI:`TTU_CTRL_MODE_LO];
  wire [1:0] s_mode = s_mfld[1] ? `TTU_CORE_CAPTURE :
                      (s_mfld == `TTU_SMODE_PWM) ? `TTU_CORE_REPEAT :
                      `TTU_CORE_COUNT;
  wire [1:0] a_mode = a_ctrl_q[`TTU_CTRL_MODE_HI:`TTU_CTRL_MODE_LO];
  wire [1:0] b_mode = b_ctrl_q[`TTU_CTRL_MODE_HI:`TTU_CTRL_MODE_LO];
  wire [1:0] a_fs = fsel_q[`TTU_FSEL_WA_HI:`TTU_FSEL_WA_LO];
  wire [1:0] b_fs = fsel_q[`TTU_FSEL_WB_HI:`TTU_FSEL_WB_LO];
  // Wide timer outputs and capture triggers are only routed when the port function matches the mode
  wire a_pin_ok = (a_mode == `TTU_CORE_CAPTURE) ?
                  (a_fs == `TTU_FSEL_CAPTURE) :
                  (a_fs == `TTU_FSEL_WA_RUN);
  wire b_pin_ok = (b_mode == `TTU_CORE_CAPTURE) ?
                  (b_fs == `TTU_FSEL_CAPTURE) :
                  (b_fs == `TTU_FSEL_WB_RUN);

  // ========================================================
  // Timer instances
  wire [7:0] s_cnt;
  wire [7:0] s_cap;
  wire [15:0] a_cnt;
  wire [15:0] a_cap;
  wire [15:0] b_cnt;
  wire [15:0] b_cap;
  wire [2:0] match;
  wire [2:0] capev;

  ttu_core #(.W(8)) u_small (
    .pclk(pclk), .presetn(presetn),
    .en(s_ctrl_q[`TTU_CTRL_EN]), .mode(s_mode), .pin_ok(1'b1),
    .tick(s_tick), .cap_edge(rise[3]),
    .period(s_per_q), .duty(s_duty_q),
    .cnt_q(s_cnt), .cap_q(s_cap),
    .toggle_q(small_timer_toggle_out), .pwm_q(small_timer_pwm_out),
    .match_q(match[0]), .capev_q(capev[0])
  );

  ttu_core #(.W(16)) u_wide_a (
    .pclk(pclk), .presetn(presetn),
    .en(a_ctrl_q[`TTU_CTRL_EN]), .mode(a_mode), .pin_ok(a_pin_ok),
    .tick(a_tick), .cap_edge(rise[4] & a_pin_ok),
    .period(a_first_q), .duty(a_second_q),
    .cnt_q(a_cnt), .cap_q(a_cap),
    .toggle_q(wide_timer_a_compare_out), .pwm_q(wide_timer_a_pwm_out),
    .match_q(match[1]), .capev_q(capev[1])
  );

  ttu_core #(.W(16)) u_wide_b (
    .pclk(pclk), .presetn(presetn),
    .en(b_ctrl_q[`TTU_CTRL_EN]), .mode(b_mode), .pin_ok(b_pin_ok),
    .tick(b_tick), .cap_edge(rise[5] & b_pin_ok),
    .period(b_first_q), .duty(b_second_q),
    .cnt_q(b_cnt), .cap_q(b_cap),
    .toggle_q(wide_timer_b_toggle_out), .pwm_q(wide_timer_b_pwm_out),
    .match_q(match[2]), .capev_q(capev[2])
  );

  // ========================================================
  // APB slave: one wait state, response registered
  wire wr_done = psel & penable & pwrite & pready;
  reg [31:0] rd_d;
  reg bad_d;

  always @* begin
    rd_d = 32'h0000_0000;
    bad_d = 1'b0;
    case (paddr)
      `TTU_OFS_SMALL_CTRL: rd_d[7:0] = s_ctrl_q;
      `TTU_OFS_SMALL_PER:  rd_d[7:0] = s_per_q;
      `TTU_OFS_SMALL_CAP:  rd_d[7:0] = s_cap;
      `TTU_OFS_SMALL_DUTY: rd_d[7:0] = s_duty_q;
      `TTU_OFS_WA_CTRL:    rd_d[7:0] = a_ctrl_q;
      `TTU_OFS_WA_FIRST:   rd_d[15:0] = a_first_q;
      `TTU_OFS_WA_SECOND:
        rd_d[15:0] = (a_mode == `TTU_CORE_CAPTURE) ? a_cap : a_second_q;
      `TTU_OFS_WB_CTRL:    rd_d[7:0] = b_ctrl_q;
      `TTU_OFS_WB_FIRST:   rd_d[15:0] = b_first_q;
      `TTU_OFS_WB_SECOND:
        rd_d[15:0] = (b_mode == `TTU_CORE_CAPTURE) ? b_cap : b_second_q;
      `TTU_OFS_PORT_FSEL:  rd_d[7:0] = fsel_q;
      `TTU_OFS_SMALL_CNT:  rd_d[7:0] = s_cnt;
      `TTU_OFS_WA_CNT:     rd_d[15:0] = a_cnt;
      `TTU_OFS_WB_CNT:     rd_d[15:0] = b_cnt;
      `TTU_OFS_IRQ_STAT:   rd_d[`TTU_IRQ_BITS-1:0] = ist_q;
      `TTU_OFS_IRQ_MASK:   rd_d[`TTU_IRQ_BITS-1:0] = imask_q;
      default: bad_d = 1'b1;
    endcase
  end

  wire [`TTU_IRQ_BITS-1:0] ev = {capev, match};
  wire [`TTU_IRQ_BITS-1:0] w1c =
    (wr_done && paddr == `TTU_OFS_IRQ_STAT) ?
    pwdata[`TTU_IRQ_BITS-1:0] : {`TTU_IRQ_BITS{1'b0}};
  // A new event wins over a clear in the same cycle
  wire [`TTU_IRQ_BITS-1:0] ist_d = (ist_q & ~w1c) | ev;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
      irq <= 1'b0;
      ist_q <= {`TTU_IRQ_BITS{1'b0}};
      imask_q <= {`TTU_IRQ_BITS{1'b0}};
      s_ctrl_q <= `TTU_RST_CTRL;
      s_per_q <= `TTU_RST_SMALL;
      s_duty_q <= 8'h00;
      a_ctrl_q <= `TTU_RST_CTRL;
      a_first_q <= `TTU_RST_WIDE;
      a_second_q <= 16'h0000;
      b_ctrl_q <= `TTU_RST_CTRL;
      b_first_q <= `TTU_RST_WIDE;
      b_second_q <= 16'h0000;
      fsel_q <= `TTU_RST_CTRL;
    end else begin
      ist_q <= ist_d;
      irq <= |(ist_d & imask_q);
      if (psel && penable && !pready) begin
        pready <= 1'b1;
        pslverr <= bad_d;
        prdata <= pwrite ? 32'h0000_0000 : rd_d;
      end else begin
        pready <= 1'b0;
        pslverr <= 1'b0;
      end
      if (wr_done) begin
        case (paddr)
          `TTU_OFS_SMALL_CTRL: s_ctrl_q <= pwdata[7:0];
          `TTU_OFS_SMALL_PER:  s_per_q <= pwdata[7:0];
          `TTU_OFS_SMALL_DUTY: s_duty_q <= pwdata[7:0];
          `TTU_OFS_WA_CTRL:    a_ctrl_q <= pwdata[7:0];
          `TTU_OFS_WA_FIRST:   a_first_q <= pwdata[15:0];
          `TTU_OFS_WA_SECOND:  a_second_q <= pwdata[15:0];
          `TTU_OFS_WB_CTRL:    b_ctrl_q <= pwdata[7:0];
          `TTU_OFS_WB_FIRST:   b_first_q <= pwdata[15:0];
          `TTU_OFS_WB_SECOND:  b_second_q <= pwdata[15:0];
          `TTU_OFS_PORT_FSEL:  fsel_q <= pwdata[7:0];
          `TTU_OFS_IRQ_MASK:   imask_q <= pwdata[`TTU_IRQ_BITS-1:0];
          default: fsel_q <= fsel_q;
        endcase
      end
    end
  end
endmodule
